/* design/chan_divider.sv */
// first output channel divider with its fixed divide by two
`timescale 1ns/10ps
`include "third_synth_channel_ft_defines.svh"
module chan_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // source and setting
  input wire logic srcTick,
  input wire logic [3:0] ratioCode,
  input wire logic powerDown,
  // divided level
  output logic divOut
);

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic divOut_r;
  logic divOut_nxt;
  logic [4:0] ratio;
  logic wrap;

  // ****************************************
  // ratio decode and count
  // ****************************************
  // code zero means sixteen
  assign ratio = third_synth_channel_ft_pkg::chanRatio(ratioCode);
  assign wrap = srcTick && (cnt_r >= ratio - 5'h01);
  // held at rest while powered down
  assign cnt_nxt = powerDown ? 5'h00 :
                   wrap ? 5'h00 :
                   srcTick ? cnt_r + 5'h01 : cnt_r;
  // toggle gives the divide by two
  assign divOut_nxt = powerDown ? 1'b0 : (wrap ? ~divOut_r : divOut_r);
  assign divOut = divOut_r;

  // counter and toggle flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
      divOut_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      divOut_r <= divOut_nxt;
    end
  end

  pdown_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    powerDown [*2] |-> !divOut_r && (cnt_r == 5'h00))
    else $error("channel divider ran while powered down");

  toggle_cause_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !$past(powerDown) && $changed(divOut_r) |-> $past(wrap))
    else $error("divider toggled without wrap");

endmodule : chan_divider

/* design/third_synth_channel_frequency_translation_cfg.sv */
// register file and setting decode of the third synth channel
`timescale 1ns/10ps
`include "third_synth_channel_ft_defines.svh"
module third_synth_channel_frequency_translation_cfg (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port from the serial control port
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // global pin configuration field and its driver settings
  input wire logic [4:0] globalPinCfg,
  input wire logic pinDrvThreeV,
  input wire logic pinDrvPowerDown,
  // source tick from loop stage b output
  input wire logic vcoTick,
  // reference section settings
  output third_synth_channel_ft_pkg::ref_mode_type refMode,
  output logic [4:0] refDivHalves,
  // loop stage settings
  output logic stageAVcoDoubler,
  output logic stageBVcoDoubler,
  output logic loopStageABypass,
  output logic [7:0] stageAFbRatio,
  output logic stageBRefBypass,
  output logic [7:0] stageBRefRatio,
  output logic loopStageBBypass,
  output logic [7:0] stageBFbRatio,
  output logic cfgRangeErr,
  // first output channel and driver
  output logic [5:0] chanEffRatio,
  output logic drvThreeV,
  output logic drvPowerDown,
  output logic firstOutput
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrl_r;
  logic [7:0] nA_r;
  logic [7:0] rB_r;
  logic [7:0] nB_r;
  logic [7:0] outDiv_r;
  logic [7:0] drv_r;
  logic [7:0] regRdData_r;
  logic regRdValid_r;
  logic [4:0] pinS1_r;
  logic [4:0] pinS2_r;
  logic [4:0] pinS3_r;
  logic [4:0] pinCfg_r;
  third_synth_channel_ft_pkg::ref_mode_type refMode_r;
  third_synth_channel_ft_pkg::ref_mode_type refMode_nxt;
  logic [4:0] refDivHalves_r;
  logic [4:0] refDivHalves_nxt;
  logic dblA_r;
  logic dblB_r;
  logic bypA_r;
  logic bypRB_r;
  logic bypB_r;
  logic [7:0] ratioA_r;
  logic [7:0] ratioRB_r;
  logic [7:0] ratioB_r;
  logic rangeErr_r;
  logic [5:0] chanEff_r;
  logic threeV_r;
  logic pdown_r;
  logic firstOutput_r;

  // ****************************************
  // address decode
  // ****************************************
  logic selCtrl;
  logic selNA;
  logic selRB;
  logic selNB;
  logic selOutDiv;
  logic selDrv;
  logic [7:0] rdMux;

  assign selCtrl = (regAddr == `FT_ADDR_CTRL);
  assign selNA = (regAddr == `FT_ADDR_NA);
  assign selRB = (regAddr == `FT_ADDR_RB);
  assign selNB = (regAddr == `FT_ADDR_NB);
  assign selOutDiv = (regAddr == `FT_ADDR_OUTDIV);
  assign selDrv = (regAddr == `FT_ADDR_DRV);
  // unmapped addresses read as zero
  assign rdMux = selCtrl ? ctrl_r :
                 selNA ? nA_r :
                 selRB ? rB_r :
                 selNB ? nB_r :
                 selOutDiv ? outDiv_r :
                 selDrv ? drv_r : 8'h00;

  // register writes, undefined bits never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `FT_RST_CTRL;
      nA_r <= `FT_RST_DIV;
      rB_r <= `FT_RST_DIV;
      nB_r <= `FT_RST_DIV;
      outDiv_r <= `FT_RST_OUTDIV;
      drv_r <= `FT_RST_DRV;
    end else if (regWrEn) begin
      if (selCtrl) ctrl_r <= regWrData & `FT_CTRL_MASK;
      if (selNA) nA_r <= regWrData;
      if (selRB) rB_r <= regWrData;
      if (selNB) nB_r <= regWrData;
      if (selOutDiv) outDiv_r <= regWrData & `FT_OUTDIV_MASK;
      if (selDrv) drv_r <= regWrData & `FT_DRV_MASK;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData_r <= 8'h00;
      regRdValid_r <= 1'b0;
    end else begin
      regRdData_r <= regRdEn ? rdMux : 8'h00;
      regRdValid_r <= regRdEn;
    end
  end

  // ****************************************
  // pin field synchroniser
  // ****************************************
  // third stage filters, the field moves only when stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_r <= 5'h00;
      pinS2_r <= 5'h00;
      pinS3_r <= 5'h00;
      pinCfg_r <= 5'h00;
    end else begin
      pinS1_r <= globalPinCfg;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      if (pinS2_r == pinS3_r) pinCfg_r <= pinS3_r;
    end
  end

  // ****************************************
  // reference section decode
  // ****************************************
  logic [3:0] refCode;
  assign refCode = ctrl_r[3:0];

  // ratio carried in halves so 1.5 stays exact
  always_comb begin
    refMode_nxt = third_synth_channel_ft_pkg::REF_DIVIDE;
    refDivHalves_nxt = 5'h02;
    unique case (refCode)
      4'h0: refMode_nxt = third_synth_channel_ft_pkg::REF_OFF;
      4'h1: refMode_nxt = third_synth_channel_ft_pkg::REF_BYPASS;
      4'h2: refDivHalves_nxt = 5'h03;
      4'h3: refDivHalves_nxt = 5'h04;
      4'h4: refDivHalves_nxt = 5'h06;
      4'h5: refDivHalves_nxt = 5'h08;
      4'h6: refDivHalves_nxt = 5'h0c;
      4'h7: refDivHalves_nxt = 5'h10;
      default: refMode_nxt = third_synth_channel_ft_pkg::REF_DOUBLE;
    endcase
  end

  // ****************************************
  // loop stage decode and range check
  // ****************************************
  logic ctlDblA;
  logic ctlDblB;
  logic errA;
  logic errRB;
  logic errB;

  assign ctlDblB = ctrl_r[`FT_CTRL_DBLB];
  assign ctlDblA = ctrl_r[`FT_CTRL_DBLA];
  // stage a feedback legal span follows its doubler
  assign errA = (nA_r != 8'h00) && !(ctlDblA ?
      third_synth_channel_ft_pkg::inRange(nA_r, `FT_FBX2_LO, `FT_FBX2_HI) :
      third_synth_channel_ft_pkg::inRange(nA_r, `FT_FB_LO, `FT_FB_HI));
  // stage b reference span follows stage a setting
  assign errRB = (rB_r != 8'h00) && !((nA_r == 8'h00) ?
      third_synth_channel_ft_pkg::inRange(rB_r, `FT_RB_LO0, `FT_RB_HI0) :
      third_synth_channel_ft_pkg::inRange(rB_r, `FT_FB_LO, `FT_FB_HI));
  // stage b feedback legal span follows its doubler
  assign errB = (nB_r != 8'h00) && !(ctlDblB ?
      third_synth_channel_ft_pkg::inRange(nB_r, `FT_FBX2_LO, `FT_FBX2_HI) :
      third_synth_channel_ft_pkg::inRange(nB_r, `FT_FB_LO, `FT_FB_HI));

  // ****************************************
  // driver selection
  // ****************************************
  logic pinActive;
  logic effThreeV;
  logic effPdown;
  logic [4:0] chanRatio;
  logic chanOut;

  assign pinActive = (pinCfg_r != 5'h00);
  // voltage bit only while the pin field is zero
  assign effThreeV = pinActive ? pinDrvThreeV : drv_r[`FT_DRV_THREEV];
  // power-down bit only while the pin field is zero
  assign effPdown = pinActive ? pinDrvPowerDown : drv_r[`FT_DRV_PDOWN];
  assign chanRatio = third_synth_channel_ft_pkg::chanRatio(outDiv_r[3:0]);

  chan_divider chan_divider_i (
    .clk(clk),
    .rst_n(rst_n),
    .srcTick(vcoTick),
    .ratioCode(outDiv_r[3:0]),
    .powerDown(effPdown),
    .divOut(chanOut)
  );

  // decoded settings registered so every output comes from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refMode_r <= third_synth_channel_ft_pkg::REF_OFF;
      refDivHalves_r <= 5'h02;
      dblA_r <= 1'b0;
      dblB_r <= 1'b0;
      bypA_r <= 1'b1;
      bypRB_r <= 1'b1;
      bypB_r <= 1'b1;
      ratioA_r <= 8'h00;
      ratioRB_r <= 8'h00;
      ratioB_r <= 8'h00;
      rangeErr_r <= 1'b0;
      chanEff_r <= 6'h20;
      threeV_r <= 1'b0;
      pdown_r <= 1'b0;
      firstOutput_r <= 1'b0;
    end else begin
      refMode_r <= refMode_nxt;
      refDivHalves_r <= refDivHalves_nxt;
      dblA_r <= ctlDblA;
      dblB_r <= ctlDblB;
      bypA_r <= (nA_r == 8'h00);
      bypRB_r <= (rB_r == 8'h00);
      bypB_r <= (nB_r == 8'h00);
      ratioA_r <= nA_r;
      ratioRB_r <= rB_r;
      ratioB_r <= nB_r;
      rangeErr_r <= errA | errRB | errB;
      // effective ratio twice the programmed one
      chanEff_r <= {chanRatio, 1'b0};
      threeV_r <= effThreeV;
      pdown_r <= effPdown;
      // invert applied at the driver, silent when down
      firstOutput_r <= effPdown ? 1'b0 : (chanOut ^ drv_r[`FT_DRV_INVERT]);
    end
  end

  // ****************************************
  // output wiring
  // ****************************************
  assign regRdData = regRdData_r;
  assign regRdValid = regRdValid_r;
  assign refMode = refMode_r;
  assign refDivHalves = refDivHalves_r;
  assign stageAVcoDoubler = dblA_r;
  assign stageBVcoDoubler = dblB_r;
  assign loopStageABypass = bypA_r;
  assign stageAFbRatio = ratioA_r;
  assign stageBRefBypass = bypRB_r;
  assign stageBRefRatio = ratioRB_r;
  assign loopStageBBypass = bypB_r;
  assign stageBFbRatio = ratioB_r;
  assign cfgRangeErr = rangeErr_r;
  assign chanEffRatio = chanEff_r;
  assign drvThreeV = threeV_r;
  assign drvPowerDown = pdown_r;
  assign firstOutput = firstOutput_r;

  // ****************************************
  // checks
  // ****************************************
  // write of bit 5 reaches the doubler two edges later
  dbl_b_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    regWrEn && selCtrl |=> ##1 stageBVcoDoubler == $past(regWrData[5], 2))
    else $error("stage b doubler not following write");

  // write of bit 4 reaches the doubler two edges later
  dbl_a_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    regWrEn && selCtrl |=> ##1 stageAVcoDoubler == $past(regWrData[4], 2))
    else $error("stage a doubler not following write");

  // code zero turns the reference off
  ref_off_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ctrl_r[3:0] == 4'h0 |=> refMode == third_synth_channel_ft_pkg::REF_OFF)
    else $error("reference not off at code zero");

  // code two divides by one and a half
  ref_div15_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ctrl_r[3:0] == 4'h2 |=> refDivHalves == 5'h03 &&
      refMode == third_synth_channel_ft_pkg::REF_DIVIDE)
    else $error("code two not divide by 1.5");

  // top bit of the code doubles
  ref_double_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ctrl_r[3] |=> refMode == third_synth_channel_ft_pkg::REF_DOUBLE)
    else $error("upper codes not doubling");

  stage_a_bypass_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    loopStageABypass |-> stageAFbRatio == 8'h00)
    else $error("stage a bypass mismatch");

  // seven is illegal once stage a divides
  rb_range_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rB_r == 8'h07 && nA_r != 8'h00
      |=> cfgRangeErr)
    else $error("stage b reference range not flagged");

  chan_ratio_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    outDiv_r[3:0] == 4'h0 |=> chanEffRatio == 6'h20)
    else $error("channel ratio at code zero wrong");

  // pin field overrides the power-down bit
  pin_override_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    pinCfg_r != 5'h00 |=> drvPowerDown == $past(pinDrvPowerDown))
    else $error("pin field did not govern power-down");

  out_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    drvPowerDown |-> !firstOutput)
    else $error("output toggling while powered down");

endmodule : third_synth_channel_frequency_translation_cfg

/* inc/third_synth_channel_ft_defines.svh */
// constants for the third synth channel frequency translation config
// Behaviour
// - Control bit 5 turns the stage B VCO doubler on when set.
// - Control bit 4 turns the stage A VCO doubler on when set.
// - Scale code 0 turns the reference off and 1 bypasses the prescaler.
// - Scaling codes 2 to 7 divide the input by 1.5, 2, 3, 4, 6 and 8.
// - Scaling codes 8 to 15 multiply the input by two.
// - Stage A feedback 0 bypasses loop A, else divides, 8-80 or 15-161.
// - Ref divider B at 0 bypasses, else 2-10 if A is 0, or 8-80.
// - Stage B feedback 0 bypasses loop B, else divides, 8-80 or 15-161.
// - Channel divider code 0 divides by 16, any other code by itself.
// - A fixed divide by two follows the channel divider.
// - The channel divider powers down whenever the driver does.
// - Voltage bit picks 1.8 V or 3.3 V, only while the pin field is 0.
// - Invert bit 0 gives normal output and 1 gives inverted output.
// - Power-down bit set turns the driver off while the pin field is 0.
`ifndef THIRD_SYNTH_CHANNEL_FT_DEFINES_SVH
`define THIRD_SYNTH_CHANNEL_FT_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define FT_ADDR_CTRL 10'h301
`define FT_ADDR_NA 10'h302
`define FT_ADDR_RB 10'h303
`define FT_ADDR_NB 10'h304
`define FT_ADDR_OUTDIV 10'h305
`define FT_ADDR_DRV 10'h306

// ****************************************
// field positions and masks
// ****************************************
`define FT_CTRL_DBLB 5
`define FT_CTRL_DBLA 4
`define FT_CTRL_MASK 8'h3f
`define FT_OUTDIV_MASK 8'h0f
`define FT_DRV_THREEV 3
`define FT_DRV_INVERT 1
`define FT_DRV_PDOWN 0
`define FT_DRV_MASK 8'h0b

// ****************************************
// reset values
// ****************************************
`define FT_RST_CTRL 8'h00
`define FT_RST_DIV 8'h00
`define FT_RST_OUTDIV 8'h00
`define FT_RST_DRV 8'h00

// ****************************************
// ranges and ratios
// ****************************************
`define FT_FB_LO 8'h08
`define FT_FB_HI 8'h50
`define FT_FBX2_LO 8'h0f
`define FT_FBX2_HI 8'ha1
`define FT_RB_LO0 8'h02
`define FT_RB_HI0 8'h0a
`define FT_CHAN_ZERO_RATIO 5'h10
`define FT_PIN_SYNC 3

`endif

/* inc/third_synth_channel_ft_pkg.sv */
// types and shared helpers for the frequency translation config
package third_synth_channel_ft_pkg;

  // reference section setting after decode
  typedef enum {
    REF_OFF,
    REF_BYPASS,
    REF_DIVIDE,
    REF_DOUBLE
  } ref_mode_type;

  typedef logic [7:0] reg_byte_type;

  // channel divider code to ratio, code 0 means sixteen
  function automatic logic [4:0] chanRatio(input logic [3:0] code);
    chanRatio = (code == 4'h0) ? 5'h10 : {1'b0, code};
  endfunction : chanRatio

  // inclusive range test for divider settings
  function automatic logic inRange(input logic [7:0] v,
                                   input logic [7:0] lo,
                                   input logic [7:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction : inRange

endpackage : third_synth_channel_ft_pkg

/* tb/third_synth_channel_frequency_translation_cfg_tb_top.sv */
// self-checking bench for the frequency translation config block
`timescale 1ns/10ps
module third_synth_channel_frequency_translation_cfg_tb_top;
  logic clk, rst_n, regWrEn, regRdEn, regRdValid;
  logic [9:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [4:0] globalPinCfg, refDivHalves;
  logic pinDrvThreeV, pinDrvPowerDown, vcoTick;
  third_synth_channel_ft_pkg::ref_mode_type refMode;
  logic stageAVcoDoubler, stageBVcoDoubler, loopStageABypass;
  logic stageBRefBypass, loopStageBBypass, cfgRangeErr;
  logic [7:0] stageAFbRatio, stageBRefRatio, stageBFbRatio;
  logic [5:0] chanEffRatio;
  logic drvThreeV, drvPowerDown, firstOutput;
  int num_errors, check_count, cycles, seed, n;
  logic [31:0] r;
  logic [7:0] d;
  logic prev;

  third_synth_channel_frequency_translation_cfg third_synth_channel_frequency_translation_cfg_i (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .globalPinCfg(globalPinCfg),
    .pinDrvThreeV(pinDrvThreeV), .pinDrvPowerDown(pinDrvPowerDown),
    .vcoTick(vcoTick), .refMode(refMode), .refDivHalves(refDivHalves),
    .stageAVcoDoubler(stageAVcoDoubler),
    .stageBVcoDoubler(stageBVcoDoubler),
    .loopStageABypass(loopStageABypass), .stageAFbRatio(stageAFbRatio),
    .stageBRefBypass(stageBRefBypass), .stageBRefRatio(stageBRefRatio),
    .loopStageBBypass(loopStageBBypass), .stageBFbRatio(stageBFbRatio),
    .cfgRangeErr(cfgRangeErr), .chanEffRatio(chanEffRatio),
    .drvThreeV(drvThreeV), .drvPowerDown(drvPowerDown),
    .firstOutput(firstOutput)
  );

  // ****************************************
  // clock, timeout and reporting
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // generous ceiling, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic cmpv(input logic [7:0] got, input logic [7:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpv

  task automatic cmpm(input third_synth_channel_ft_pkg::ref_mode_type got,
                      input third_synth_channel_ft_pkg::ref_mode_type exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpm

  // ****************************************
  // register port tasks
  // ****************************************
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  // answer stands only until the edge after the read edge
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    cmpv({7'h00, regRdValid}, 8'h01);
    cmpv(regRdData, exp);
  endtask : rd

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : settle

  // ****************************************
  // expectation functions
  // ****************************************
  function automatic logic [7:0] expHalves(input logic [3:0] c);
    case (c)
      4'h2: return 8'h03;
      4'h3: return 8'h04;
      4'h4: return 8'h06;
      4'h5: return 8'h08;
      4'h6: return 8'h0c;
      4'h7: return 8'h10;
      default: return 8'h02;
    endcase
  endfunction : expHalves

  function automatic third_synth_channel_ft_pkg::ref_mode_type expMode(input logic [3:0] c);
    if (c == 4'h0) return third_synth_channel_ft_pkg::REF_OFF;
    if (c == 4'h1) return third_synth_channel_ft_pkg::REF_BYPASS;
    if (c < 4'h8) return third_synth_channel_ft_pkg::REF_DIVIDE;
    return third_synth_channel_ft_pkg::REF_DOUBLE;
  endfunction : expMode

  function automatic logic expErr(input logic [7:0] c, na, rb, nb);
    logic ea, eb, er;
    ea = na != 0 && (c[4] ? (na < 15 || na > 161) : (na < 8 || na > 80));
    eb = nb != 0 && (c[5] ? (nb < 15 || nb > 161) : (nb < 8 || nb > 80));
    er = rb != 0 && (na == 0 ? (rb < 2 || rb > 10) : (rb < 8 || rb > 80));
    return ea | eb | er;
  endfunction : expErr

  // ****************************************
  // scenario tasks
  // ****************************************
  task automatic cfg(input logic [7:0] c, na, rb, nb);
    wr(10'h301, c);
    wr(10'h302, na);
    wr(10'h303, rb);
    wr(10'h304, nb);
    settle(3);
    cmpm(refMode, expMode(c[3:0]));
    cmpv({3'h0, refDivHalves}, expHalves(c[3:0]));
    cmpv({7'h00, stageBVcoDoubler}, {7'h00, c[5]});
    cmpv({7'h00, stageAVcoDoubler}, {7'h00, c[4]});
    cmpv({7'h00, loopStageABypass}, {7'h00, na == 0});
    cmpv(stageAFbRatio, na);
    cmpv({7'h00, stageBRefBypass}, {7'h00, rb == 0});
    cmpv(stageBRefRatio, rb);
    cmpv({7'h00, loopStageBBypass}, {7'h00, nb == 0});
    cmpv(stageBFbRatio, nb);
    cmpv({7'h00, cfgRangeErr}, {7'h00, expErr(c, na, rb, nb)});
    rd(10'h301, c & 8'h3f);
  endtask : cfg

  // channel level half period in ticks, ticks arrive every cycle
  task automatic period(input logic [3:0] code);
    wr(10'h305, {4'h0, code});
    settle(3);
    prev = firstOutput;
    n = 0;
    while (firstOutput === prev && n < 40) begin
      settle(1);
      n = n + 1;
    end
    prev = firstOutput;
    n = 0;
    while (firstOutput === prev && n < 40) begin
      settle(1);
      n = n + 1;
    end
    cmpv(n[7:0], (code == 4'h0) ? 8'h10 : {4'h0, code});
  endtask : period

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 74190;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    rst_n = 1'b0;
    regAddr = 10'h000;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    globalPinCfg = 5'h00;
    pinDrvThreeV = 1'b0;
    pinDrvPowerDown = 1'b0;
    vcoTick = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);
    cmpv({2'h0, chanEffRatio}, 8'h20);
    cmpm(refMode, third_synth_channel_ft_pkg::REF_OFF);
    for (int a = 10'h300; a <= 10'h307; a++) begin
      rd(a[9:0], 8'h00);
    end
    // corners of the legal divider spans
    cfg(8'h30, 8'd161, 8'd80, 8'd15);
    cfg(8'h00, 8'd81, 8'd0, 8'd7);
    cfg(8'h00, 8'd0, 8'd10, 8'd8);
    cfg(8'hc2, 8'd0, 8'd11, 8'd0);
    cfg(8'h10, 8'd14, 8'd8, 8'd80);
    cfg(8'h20, 8'd8, 8'd7, 8'd162);
    // every scaling code, random doublers and dividers
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      cfg({r[7:4], i[3:0]}, r[11:8] == 0 ? 8'h00 : r[19:12],
          r[23:20] == 0 ? 8'h00 : {3'h0, r[28:24]}, r[31:24]);
    end
    // every channel code, reserved upper bits random
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      wr(10'h305, {r[7:4], i[3:0]});
      settle(3);
      d = (i == 0) ? 8'h20 : {3'h0, i[3:0], 1'b0};
      cmpv({2'h0, chanEffRatio}, d);
      rd(10'h305, {4'h0, i[3:0]});
    end
    vcoTick <= 1'b1;
    period(4'h1);
    period(4'h3);
    period(4'h0);
    // power-down holds the divider quiet even with ticks running
    wr(10'h306, 8'h07);
    settle(20);
    cmpv({7'h00, drvPowerDown}, 8'h01);
    cmpv({7'h00, firstOutput}, 8'h00);
    rd(10'h306, 8'h03);
    vcoTick <= 1'b0;
    wr(10'h306, 8'h0a);
    settle(4);
    cmpv({7'h00, firstOutput}, 8'h01);
    cmpv({7'h00, drvThreeV}, 8'h01);
    wr(10'h306, 8'h00);
    settle(4);
    cmpv({7'h00, firstOutput}, 8'h00);
    // pin field override against register bits
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      globalPinCfg <= (i < 3) ? 5'h00 : r[4:0];
      pinDrvThreeV <= r[5];
      pinDrvPowerDown <= r[6];
      wr(10'h306, r[15:8]);
      settle(6);
      if ((i < 3) || r[4:0] == 5'h00) begin
        cmpv({7'h00, drvThreeV}, {7'h00, r[11]});
        cmpv({7'h00, drvPowerDown}, {7'h00, r[8]});
      end else begin
        cmpv({7'h00, drvThreeV}, {7'h00, r[5]});
        cmpv({7'h00, drvPowerDown}, {7'h00, r[6]});
      end
    end
    close_out();
  end
endmodule : third_synth_channel_frequency_translation_cfg_tb_top
